// File: hw/sfp_dev.sv
`timescale 1ns/1ps
`include "sfp_cfg.svh"
module sfp_dev
    import sfp_pkg::*;
#(
    parameter int         PROG_CYC = `SFP_PROG_US * `SFP_CLK_MHZ,
    parameter int         SECT_CYC = `SFP_SECT_US * `SFP_CLK_MHZ,
    parameter int         CHIP_CYC = `SFP_CHIP_US * `SFP_CLK_MHZ,
    parameter logic [7:0] SIG_ID   = 8'h5a
) (
    input  wire logic pclk,
    input  wire logic presetn,
    sfp_if.dev        link,
    output logic      busy_o,
    output logic      wel_o,
    output logic      dpd_o
);
    localparam int AW = `SFP_ADDR_W;
    localparam int PW = `SFP_PAGE_W;
    localparam int SW = `SFP_SECT_W;
    localparam int BW = `SFP_BLK_W;

    // ----------------------------------------------------------------
    // Pin sampling and edge finding
    // ----------------------------------------------------------------
    logic [4:0] s;
    logic       cs_n_s, sclk_s, d0_s, pause_n_s, guard_n_s;
    logic       sclk_p_q, cs_p_q, hold_q;
    logic       rise, fall, cs_rise, cs_fall;

    sfp_sync #(.W(5)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({link.guard_n, link.pause_n, link.data_line0, link.sclk, link.cs_n}),
        .q       (s)
    );
    assign {guard_n_s, pause_n_s, d0_s, sclk_s, cs_n_s} = s;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_p_q <= 1'h0;
            cs_p_q   <= 1'h1;
        end
        else
        begin
            sclk_p_q <= sclk_s;
            cs_p_q   <= cs_n_s;
        end
    end
    // Clock edges seen during a pause are dropped entirely; select edges still count.
    assign rise    = sclk_s & ~sclk_p_q & ~cs_n_s & ~hold_q;
    assign fall    = ~sclk_s & sclk_p_q & ~cs_n_s & ~hold_q;
    assign cs_rise = cs_n_s & ~cs_p_q;
    assign cs_fall = ~cs_n_s & cs_p_q;

    // Pause follows the pin only while the clock is low.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_q <= 1'h0;
        else if (cs_n_s)
            hold_q <= 1'h0;
        else if (!sclk_s)
            hold_q <= ~pause_n_s;
    end

    // ----------------------------------------------------------------
    // Byte assembly and command state
    // ----------------------------------------------------------------
    logic [2:0]  bit_q;
    logic [7:0]  in_sr_q, byte_w, sw_data_q, opc_q;
    logic [15:0] nbyte_q;
    logic [23:0] addr_q, addr_nx;
    logic        byte_done, busy_q, dpd_q, wel_q, lock_q;
    logic [1:0]  bp_q;
    sfp_dev_st_t st_q;

    assign byte_w    = {in_sr_q[6:0], d0_s};
    assign byte_done = rise & (bit_q == 3'h7);
    assign addr_nx   = {addr_q[15:0], byte_w};

    function automatic sfp_dev_st_t f_decode(input logic [7:0] b, input logic bsy,
                                             input logic pd);
        sfp_dev_st_t r;
        r = DS_IGN;
        if (pd)
            r = (b == `SFP_OP_WAKE) ? DS_ARG : DS_IGN;
        else if (bsy)
            r = (b == `SFP_OP_RDSR) ? DS_OUT : DS_IGN;
        else
            case (b)
                `SFP_OP_RDSR: r = DS_OUT;
                `SFP_OP_WEN, `SFP_OP_WDI, `SFP_OP_STATUS_WRITE_CMD, `SFP_OP_READ, `SFP_OP_FAST,
                `SFP_OP_DREAD, `SFP_OP_PP, `SFP_OP_SE, `SFP_OP_BE1, `SFP_OP_BE2,
                `SFP_OP_CE1, `SFP_OP_CE2, `SFP_OP_DPD, `SFP_OP_WAKE: r = DS_ARG;
                default: r = DS_IGN;
            endcase
        return r;
    endfunction : f_decode

    function automatic logic [15:0] f_need(input logic [7:0] op);
        return (op == `SFP_OP_FAST) ? 16'h0004 :
               (op == `SFP_OP_READ || op == `SFP_OP_DREAD || op == `SFP_OP_WAKE) ?
               16'h0003 : 16'hffff;
    endfunction : f_need

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_q   <= 3'h0;
            in_sr_q <= 8'h00;
        end
        else if (cs_n_s)
            bit_q <= 3'h0;
        else if (rise)
        begin
            in_sr_q <= byte_w;
            bit_q   <= bit_q + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q      <= DS_IDLE;
            opc_q     <= 8'h00;
            nbyte_q   <= 16'h0000;
            addr_q    <= 24'h000000;
            sw_data_q <= 8'h00;
        end
        else if (cs_n_s)
            st_q <= DS_IDLE;
        else if (cs_fall)
        begin
            st_q    <= DS_OPC;
            nbyte_q <= 16'h0000;
        end
        else if (byte_done)
        begin
            case (st_q)
                DS_OPC:
                begin
                    opc_q <= byte_w;
                    st_q  <= f_decode(byte_w, busy_q, dpd_q);
                end
                DS_ARG:
                begin
                    if (nbyte_q != 16'hffff)
                        nbyte_q <= nbyte_q + 16'h0001;
                    if (nbyte_q < 16'h0003)
                        addr_q <= addr_nx;
                    if (nbyte_q == 16'h0000)
                        sw_data_q <= byte_w;
                    if (nbyte_q + 16'h0001 == f_need(opc_q))
                        st_q <= DS_OUT;
                end
                default: st_q <= st_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Command completion at deselect
    // ----------------------------------------------------------------
    logic [AW-1:0] a;
    logic exec, go, grd, done, go_prog, go_sect, go_blk, go_chip, go_sw;

    assign a    = addr_q[AW-1:0];
    assign exec = cs_rise & (st_q == DS_ARG) & (bit_q == 3'h0);
    assign go   = exec & wel_q;
    assign grd  = (bp_q == 2'h0) ? 1'h0 : (bp_q == 2'h1) ? a[AW-1] : 1'h1;
    assign go_prog = go & (opc_q == `SFP_OP_PP) & (nbyte_q > 16'h0003) & ~grd;
    assign go_sect = go & (opc_q == `SFP_OP_SE) & (nbyte_q == 16'h0003) & ~grd;
    assign go_blk  = go & (opc_q == `SFP_OP_BE1 || opc_q == `SFP_OP_BE2)
                   & (nbyte_q == 16'h0003) & ~grd;
    assign go_chip = go & (opc_q == `SFP_OP_CE1 || opc_q == `SFP_OP_CE2)
                   & (nbyte_q == 16'h0000) & (bp_q == 2'h0);
    assign go_sw   = go & (opc_q == `SFP_OP_STATUS_WRITE_CMD) & (nbyte_q == 16'h0001)
                   & ~(lock_q & ~guard_n_s);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wel_q <= 1'h0;
        else if (exec & (nbyte_q == 16'h0000) & (opc_q == `SFP_OP_WEN))
            wel_q <= 1'h1;
        else if ((exec & (nbyte_q == 16'h0000) & (opc_q == `SFP_OP_WDI)) | done)
            wel_q <= 1'h0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bp_q   <= 2'h0;
            lock_q <= 1'h0;
        end
        else if (go_sw)
        begin
            bp_q   <= sw_data_q[`SFP_SR_BPHI:`SFP_SR_BPLO];
            lock_q <= sw_data_q[`SFP_SR_LOCK];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dpd_q <= 1'h0;
        else if (exec & (opc_q == `SFP_OP_DPD) & (nbyte_q == 16'h0000))
            dpd_q <= 1'h1;
        else if ((exec | (cs_rise & (st_q == DS_OUT))) & (opc_q == `SFP_OP_WAKE))
            dpd_q <= 1'h0;
    end

    // ----------------------------------------------------------------
    // Self-timed program and erase engine
    // ----------------------------------------------------------------
    // The walk touches one byte a cycle; busy ends once both the walk and the timer are done.
    logic [AW-1:0] ptr_q, end_q;
    logic [31:0]   tmr_q;
    logic          walk_q, wipe_q;
    logic [7:0]    mem_q [0:(1 << AW) - 1];
    logic [7:0]    pbuf_q [0:(1 << PW) - 1];

    assign done = busy_q & ~walk_q & (tmr_q == 32'h0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q <= 1'h0;
            walk_q <= 1'h0;
            wipe_q <= 1'h0;
            tmr_q  <= 32'h0;
            ptr_q  <= '0;
            end_q  <= '0;
        end
        else if (go_prog | go_sect | go_blk | go_chip | go_sw)
        begin
            busy_q <= 1'h1;
            walk_q <= ~go_sw;
            wipe_q <= ~go_prog;
            tmr_q  <= go_sw ? 32'h1 : go_prog ? 32'(PROG_CYC) :
                      go_sect ? 32'(SECT_CYC) : 32'(CHIP_CYC);
            ptr_q  <= go_chip ? '0 : go_blk ? {a[AW-1:BW], {BW{1'h0}}} :
                      go_sect ? {a[AW-1:SW], {SW{1'h0}}} : {a[AW-1:PW], {PW{1'h0}}};
            end_q  <= go_chip ? '1 : go_blk ? {a[AW-1:BW], {BW{1'h1}}} :
                      go_sect ? {a[AW-1:SW], {SW{1'h1}}} : {a[AW-1:PW], {PW{1'h1}}};
        end
        else if (busy_q)
        begin
            // Keeps running through a pause or a deselect.
            if (walk_q)
            begin
                ptr_q  <= ptr_q + AW'(1);
                walk_q <= (ptr_q != end_q);
            end
            if (tmr_q != 32'h0)
                tmr_q <= tmr_q - 32'h1;
            if (done)
                busy_q <= 1'h0;
        end
    end

    // Programming only clears bits; unwritten buffer bytes stay all ones.
    always_ff @(posedge pclk)
    begin
        if (busy_q & walk_q)
            mem_q[ptr_q] <= wipe_q ? 8'hff : (mem_q[ptr_q] & pbuf_q[ptr_q[PW-1:0]]);
        if (byte_done & (st_q == DS_OPC) & (byte_w == `SFP_OP_PP))
        begin
            for (int i = 0; i < (1 << PW); i++)
                pbuf_q[i] <= 8'hff;
        end
        else if (byte_done & (st_q == DS_ARG) & (opc_q == `SFP_OP_PP) &
                 (nbyte_q > 16'h0002))
            pbuf_q[addr_q[PW-1:0] + nbyte_q[PW-1:0] - 8'h03] <= byte_w;
    end

    // ----------------------------------------------------------------
    // Read-out path
    // ----------------------------------------------------------------
    logic [AW-1:0] raddr_q;
    logic [2:0]    obit_q, step;
    logic [3:0]    onx;
    logic [7:0]    cur, sr;
    logic          live_q, dual, d0_q, d1_q, oe0_q, oe1_q;

    assign sr   = {lock_q, 3'h0, bp_q, wel_q, busy_q};
    assign dual = (opc_q == `SFP_OP_DREAD);
    assign step = dual ? 3'h2 : 3'h1;
    assign onx  = {1'h0, obit_q} + {1'h0, step};
    assign cur  = (opc_q == `SFP_OP_RDSR) ? sr : (opc_q == `SFP_OP_WAKE) ? SIG_ID :
                  mem_q[raddr_q];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            raddr_q <= '0;
            obit_q  <= 3'h0;
            live_q  <= 1'h0;
            d0_q    <= 1'h0;
            d1_q    <= 1'h0;
        end
        else if (cs_n_s)
        begin
            obit_q <= 3'h0;
            live_q <= 1'h0;
        end
        else if (byte_done & (st_q == DS_ARG))
            raddr_q <= (nbyte_q == 16'h0002) ? addr_nx[AW-1:0] : a;
        else if (fall & (st_q == DS_OUT))
        begin
            live_q <= 1'h1;
            d1_q   <= cur[3'h7 - obit_q];
            if (dual)
                d0_q <= cur[3'h6 - obit_q];
            obit_q <= onx[2:0];
            if (onx[3])
                raddr_q <= raddr_q + AW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oe0_q <= 1'h0;
            oe1_q <= 1'h0;
        end
        else
        begin
            oe1_q <= live_q & (st_q == DS_OUT) & ~hold_q & ~cs_n_s;
            oe0_q <= live_q & (st_q == DS_OUT) & ~hold_q & ~cs_n_s & dual;
        end
    end

    assign link.d_d0    = d0_q;
    assign link.d_d1    = d1_q;
    assign link.d_d0_oe = oe0_q;
    assign link.d_d1_oe = oe1_q;
    assign busy_o       = busy_q;
    assign wel_o        = wel_q;
    assign dpd_o        = dpd_q;
endmodule : sfp_dev

// File: hw/sfp_cfg.svh
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH
// What this block does
// - SPI slave in clock modes 0 and 3
// - 32 sectors of 4K, 2 blocks of 64K
// - Page write 256 bytes; self-timed erase
// - Host writes only to erased pages
// - Dual read drives both data lines
// - Host clock at most 104/80 MHz
// - Busy bit shows program or erase
// - Idle and deselected means standby
// - Power-up to standby; array changes after commands
// - Modifying commands must end on byte boundary
// - Write latch must precede modifying commands
// - Latch cleared by reset and completions
// - Protect level 0 none, 1 upper, 2-3 all
// - Guard pin low with lock bit set freezes protect and lock
// - Deep power-down accepts only wake/signature
// - Pause stops link, not internal operations
// - Pause starts with clock low
// - Pause ends with clock low
// - Paused: output floats, inputs ignored
// - Deselect during pause resets interface
// - Sample on rising, shift on falling edge
// - Unknown opcode: standby until next select

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SFP_OP_WEN   8'h06
`define SFP_OP_WDI   8'h04
`define SFP_OP_RDSR  8'h05
`define SFP_OP_STATUS_WRITE_CMD  8'h01
`define SFP_OP_READ  8'h03
`define SFP_OP_FAST  8'h0b
`define SFP_OP_DREAD 8'h3b
`define SFP_OP_PP    8'h02
`define SFP_OP_SE    8'h20
`define SFP_OP_BE1   8'h52
`define SFP_OP_BE2   8'hd8
`define SFP_OP_CE1   8'h60
`define SFP_OP_CE2   8'hc7
`define SFP_OP_DPD   8'hb9
`define SFP_OP_WAKE  8'hab

// ----------------------------------------------------------------
// Geometry, status bits, timing
// ----------------------------------------------------------------
`define SFP_ADDR_W   17
`define SFP_PAGE_W   8
`define SFP_SECT_W   12
`define SFP_BLK_W    16
`define SFP_SR_LOCK  7
`define SFP_SR_BPHI  3
`define SFP_SR_BPLO  2
`define SFP_CLK_MHZ  125
`define SFP_PROG_US  5000
`define SFP_SECT_US  60000
`define SFP_CHIP_US  2000000
`define SFP_SCLK_HALF 10

// ----------------------------------------------------------------
// Controller registers (byte offsets)
// ----------------------------------------------------------------
`define SFP_REG_CTRL 8'h00
`define SFP_REG_TXD  8'h04
`define SFP_REG_RXD  8'h08
`define SFP_REG_STAT 8'h0c
`define SFP_REG_PINS 8'h10
`endif

// File: hw/sfp_pkg.sv
package sfp_pkg;
    typedef enum logic [2:0] {DS_IDLE, DS_OPC, DS_ARG, DS_OUT, DS_IGN} sfp_dev_st_t;
    typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_END} sfp_host_st_t;
endpackage : sfp_pkg

// File: hw/sfp_if.sv
`timescale 1ns/1ps
interface sfp_if;
    logic cs_n;
    logic sclk;
    logic pause_n;
    logic guard_n;
    logic h_d0;
    logic h_d0_oe;
    logic d_d0;
    logic d_d0_oe;
    logic d_d1;
    logic d_d1_oe;
    logic data_line0;
    logic data_line1;
    // Undriven lines read as pulled high.
    assign data_line0 = h_d0_oe ? h_d0 : (d_d0_oe ? d_d0 : 1'h1);
    assign data_line1 = d_d1_oe ? d_d1 : 1'h1;
    modport dev (input cs_n, sclk, pause_n, guard_n, data_line0,
                 output d_d0, d_d0_oe, d_d1, d_d1_oe);
    modport host (output cs_n, sclk, pause_n, guard_n, h_d0, h_d0_oe,
                  input data_line0, data_line1);
endinterface : sfp_if

// File: hw/sfp_sync.sv
`timescale 1ns/1ps
module sfp_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] m_q;
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                m_q[i] <= 1'h1;
                q[i]   <= 1'h1;
            end
            else
            begin
                m_q[i] <= d[i];
                q[i]   <= m_q[i];
            end
        end
    end
endmodule : sfp_sync

// File: hw/sfp_host.sv
`timescale 1ns/1ps
`include "sfp_cfg.svh"
module sfp_host
    import sfp_pkg::*;
#(
    parameter int HALF = `SFP_SCLK_HALF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    sfp_if.host              link
);
    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    logic [31:0] ctrl_q, txd_q, rxd_q, rd;
    logic [1:0]  pins_q;
    logic        wr, start, mapped, busy;
    sfp_host_st_t st_q;

    assign busy   = (st_q != HS_IDLE);
    assign mapped = (paddr == `SFP_REG_CTRL) | (paddr == `SFP_REG_TXD) |
                    (paddr == `SFP_REG_RXD) | (paddr == `SFP_REG_STAT) |
                    (paddr == `SFP_REG_PINS);
    assign wr     = psel & penable & pready & pwrite & mapped;
    assign start  = wr & (paddr == `SFP_REG_CTRL) & pwdata[31] & ~busy;
    always_comb
    begin
        case (paddr)
            `SFP_REG_CTRL: rd = {1'h0, ctrl_q[30:0]};
            `SFP_REG_TXD:  rd = txd_q;
            `SFP_REG_RXD:  rd = rxd_q;
            `SFP_REG_STAT: rd = {31'h0, busy};
            `SFP_REG_PINS: rd = {30'h0, pins_q};
            default:       rd = 32'h0;
        endcase
    end

    // One wait state lets every bus output come from a flip-flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'h0;
            pslverr <= 1'h0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata  <= rd;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= 32'h0;
            txd_q  <= 32'h0;
            pins_q <= 2'h0;
        end
        else if (wr)
        begin
            if ((paddr == `SFP_REG_CTRL) & ~busy)
                ctrl_q <= pwdata;
            if ((paddr == `SFP_REG_TXD) & ~busy)
                txd_q <= pwdata;
            if (paddr == `SFP_REG_PINS)
                pins_q <= pwdata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Link engine, clock mode 0
    // ----------------------------------------------------------------
    logic [1:0]  s;
    logic [39:0] tx_q;
    logic [15:0] div_q;
    logic [6:0]  cnt_q, txc, tot;
    logic        tick, stall, dual, sclk_q, cs_n_q, d0_q, oe_q, pause_n_q;

    sfp_sync #(.W(2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({link.data_line1, link.data_line0}),
        .q       (s)
    );
    assign dual = ctrl_q[16];
    assign txc  = {1'h0, ctrl_q[10:8], 3'h0} + 7'h08;
    assign tot  = txc + (dual ? {2'h0, ctrl_q[14:12], 2'h0} : {1'h0, ctrl_q[14:12], 3'h0});
    // The clock stays low while paused and until the pause pin is back up, so the
    // slave never sees the pin rise together with the clock.
    assign stall = (pins_q[0] | ~pause_n_q) & ~sclk_q;
    assign tick  = (div_q == 16'(HALF - 1)) & ~stall;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pause_n_q <= 1'h1;
        else if (~sclk_q)
            pause_n_q <= ~pins_q[0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q   <= HS_IDLE;
            div_q  <= 16'h0;
            cnt_q  <= 7'h0;
            sclk_q <= 1'h0;
            cs_n_q <= 1'h1;
            d0_q   <= 1'h0;
            oe_q   <= 1'h0;
            tx_q   <= 40'h0;
            rxd_q  <= 32'h0;
        end
        else if (start)
        begin
            st_q   <= HS_RUN;
            div_q  <= 16'h0;
            cnt_q  <= 7'h0;
            cs_n_q <= 1'h0;
            d0_q   <= pwdata[7];
            oe_q   <= 1'h1;
            tx_q   <= {pwdata[6:0], txd_q, 1'h0};
            rxd_q  <= 32'h0;
        end
        else if (busy)
        begin
            div_q <= tick ? 16'h0 : stall ? div_q : div_q + 16'h1;
            if (tick & (st_q == HS_END))
            begin
                st_q   <= HS_IDLE;
                cs_n_q <= 1'h1;
                oe_q   <= 1'h0;
            end
            else if (tick & ~sclk_q)
                sclk_q <= 1'h1;
            else if (tick)
            begin
                // Sample just before the falling edge, when the slave's bit is settled.
                sclk_q <= 1'h0;
                cnt_q  <= cnt_q + 7'h1;
                if (cnt_q >= txc)
                    rxd_q <= dual ? {rxd_q[29:0], s[1], s[0]} : {rxd_q[30:0], s[1]};
                if (cnt_q + 7'h1 == tot)
                    st_q <= HS_END;
                else if (cnt_q + 7'h1 < txc)
                begin
                    d0_q <= tx_q[39];
                    tx_q <= {tx_q[38:0], 1'h0};
                end
                else
                    oe_q <= ~dual;
            end
        end
    end

    assign link.cs_n    = cs_n_q;
    assign link.sclk    = sclk_q;
    assign link.h_d0    = d0_q;
    assign link.h_d0_oe = oe_q;
    assign link.pause_n = pause_n_q;
    assign link.guard_n = ~pins_q[1];
endmodule : sfp_host

// File: sim/sfp_chk_sva.sv
`timescale 1ns/1ps
module sfp_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic pause_n,
    input wire logic d_d0_oe,
    input wire logic d_d1,
    input wire logic d_d1_oe,
    input wire logic busy_o,
    input wire logic wel_o,
    input wire logic dpd_o
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Pins reach the device through a two-flop synchroniser, so eight cycles bound a float.
    sequence idle8;
        cs_n [*8];
    endsequence
    sequence held8;
        !pause_n [*8];
    endsequence
    a_idle_float: assert property (idle8 |-> !d_d0_oe && !d_d1_oe)
        else $error("driven while idle");
    a_pause_float: assert property (held8 |-> !d_d1_oe)
        else $error("driven while paused");
    a_busy_deselect: assert property ($rose(busy_o) |-> cs_n)
        else $error("busy inside frame");
    a_busy_latch: assert property ($rose(busy_o) |-> wel_o)
        else $error("busy without latch");
    a_latch_clear: assert property ($fell(busy_o) |-> ##[0:2] !wel_o)
        else $error("latch kept");
    a_sleep_lock: assert property (($rose(wel_o) || $rose(busy_o)) |-> !dpd_o)
        else $error("write in power-down");
    a_dual_pair: assert property (d_d0_oe |-> d_d1_oe)
        else $error("line0 alone");
    a_shift_fall: assert property (d_d1_oe && $past(d_d1_oe) && $changed(d_d1) |-> !sclk)
        else $error("shift off falling edge");
endmodule : sfp_chk

// File: sim/tb.sv
`timescale 1ns/1ps
`include "sfp_cfg.svh"
module tb;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        pready, pslverr, er, busy_o, wel_o, dpd_o;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          n_fail = 0, num_checks = 0;
    sfp_if lk ();
    sfp_host sfp_host_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .link(lk));
    // Short wipe counts keep the run brief; the SIG_ID value is arbitrary.
    sfp_dev #(.PROG_CYC(300), .SECT_CYC(300), .CHIP_CYC(300), .SIG_ID(8'h3c))
        sfp_dev_i (.pclk, .presetn, .link(lk), .busy_o, .wel_o, .dpd_o);
    sfp_chk sfp_chk_i (.pclk, .presetn, .cs_n(lk.cs_n), .sclk(lk.sclk), .pause_n(lk.pause_n),
        .d_d0_oe(lk.d_d0_oe), .d_d1(lk.d_d1), .d_d1_oe(lk.d_d1_oe), .busy_o, .wel_o, .dpd_o);
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic frame(input logic [7:0] op, input logic [2:0] nt, nr, input logic dl,
                         input logic [31:0] tx);
        apb(1'h1, `SFP_REG_TXD, tx);
        apb(1'h1, `SFP_REG_CTRL, {1'h1, 14'h0, dl, 1'h0, nr, 1'h0, nt, op});
        do apb(1'h0, `SFP_REG_STAT, 32'h0); while (rd[0]);
        apb(1'h0, `SFP_REG_RXD, 32'h0);
        repeat (8) @(posedge pclk);
    endtask : frame
    task automatic cmd(input logic [7:0] op);
        frame(op, 3'h0, 3'h0, 1'h0, 32'h0);
    endtask : cmd
    task automatic wait_ready;
        do frame(`SFP_OP_RDSR, 3'h0, 3'h1, 1'h0, 32'h0); while (rd[0]);
    endtask : wait_ready
    task automatic s_latch;
        chk("wel", 1'h0, wel_o);
        chk("dpd", 1'h0, dpd_o);
        apb(1'h0, 8'h14, 32'h0);
        chk("slverr", 1'h1, er);
        frame(`SFP_OP_WEN, 3'h1, 3'h0, 1'h0, 32'h0);
        chk("wel", 1'h0, wel_o);
        frame(8'h77, 3'h0, 3'h1, 1'h0, 32'h0);
        chk("unknown", 32'hff, rd);
        cmd(`SFP_OP_WEN);
        chk("wel", 1'h1, wel_o);
        cmd(`SFP_OP_WDI);
        chk("wel", 1'h0, wel_o);
    endtask : s_latch
    task automatic s_flash;
        cmd(`SFP_OP_WEN);
        frame(`SFP_OP_SE, 3'h3, 3'h0, 1'h0, 32'h0);
        frame(`SFP_OP_RDSR, 3'h0, 3'h1, 1'h0, 32'h0);
        chk("wip", 1'h1, rd[0]);
        wait_ready;
        chk("wel", 1'h0, wel_o);
        cmd(`SFP_OP_WEN);
        frame(`SFP_OP_PP, 3'h4, 3'h0, 1'h0, 32'h000000a5);
        wait_ready;
        frame(`SFP_OP_READ, 3'h3, 3'h4, 1'h0, 32'h0);
        chk("read", 32'ha5ffffff, rd);
        frame(`SFP_OP_DREAD, 3'h3, 3'h4, 1'h1, 32'h0);
        chk("dual", 32'ha5ffffff, rd);
    endtask : s_flash
    task automatic s_prot;
        cmd(`SFP_OP_WEN);
        frame(`SFP_OP_STATUS_WRITE_CMD, 3'h1, 3'h0, 1'h0, 32'h84000000);
        wait_ready;
        apb(1'h1, `SFP_REG_PINS, 32'h2);
        cmd(`SFP_OP_WEN);
        frame(`SFP_OP_STATUS_WRITE_CMD, 3'h1, 3'h0, 1'h0, 32'h0);
        frame(`SFP_OP_RDSR, 3'h0, 3'h1, 1'h0, 32'h0);
        chk("guard", 32'h86, rd);
        cmd(`SFP_OP_WEN);
        frame(`SFP_OP_SE, 3'h3, 3'h0, 1'h0, 32'h01000000);
        chk("busy", 1'h0, busy_o);
        chk("wel", 1'h1, wel_o);
        frame(`SFP_OP_PP, 3'h4, 3'h0, 1'h0, 32'h0000015a);
        wait_ready;
        frame(`SFP_OP_READ, 3'h3, 3'h4, 1'h0, 32'h0);
        chk("low", 32'ha55affff, rd);
    endtask : s_prot
    task automatic s_dpd;
        cmd(`SFP_OP_DPD);
        chk("dpd", 1'h1, dpd_o);
        cmd(`SFP_OP_WEN);
        chk("wel", 1'h0, wel_o);
        frame(`SFP_OP_WAKE, 3'h3, 3'h1, 1'h0, 32'h0);
        chk("dpd", 1'h0, dpd_o);
        chk("sig", 8'h3c, rd[7:0]);
    endtask : s_dpd
    task automatic s_pause;
        apb(1'h1, `SFP_REG_TXD, 32'h0);
        apb(1'h1, `SFP_REG_CTRL, 32'h80004303);
        repeat (700) @(posedge pclk);
        apb(1'h1, `SFP_REG_PINS, 32'h1);
        repeat (40) @(posedge pclk);
        chk("sclk", 1'h0, lk.sclk);
        chk("float", 1'h0, lk.d_d1_oe);
        apb(1'h1, `SFP_REG_PINS, 32'h0);
        do apb(1'h0, `SFP_REG_STAT, 32'h0); while (rd[0]);
        apb(1'h0, `SFP_REG_RXD, 32'h0);
        chk("held", 32'ha55affff, rd);
    endtask : s_pause
    task automatic finish_test;
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    initial
    begin
        forever #4 pclk = ~pclk;
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        repeat (3) @(posedge pclk);
        s_latch;
        s_flash;
        s_prot;
        s_dpd;
        s_pause;
        finish_test;
    end
    initial
    begin
        #400000;
        n_fail++;
        finish_test;
    end
endmodule : tb
